// [hw/cbt_pkg.sv]
// constants and types shared by the bit timing and transmit buffer block
`default_nettype none
package cbt_pkg;
   // ***************************************************************
   // register byte addresses
   // ***************************************************************
   localparam logic [7:0] ADDR_CONTROL   = 8'h00;
   localparam logic [7:0] ADDR_RX_FLAGS  = 8'h04;
   localparam logic [7:0] ADDR_RX_IRQ_EN = 8'h08;
   localparam logic [7:0] ADDR_TIMING    = 8'h0C;
   localparam logic [7:0] ADDR_TX_EMPTY  = 8'h10;
   localparam logic [7:0] ADDR_TX_SELECT = 8'h14;
   localparam logic [7:0] ADDR_PRESCALE  = 8'h18;
   localparam logic [7:0] ADDR_STATUS    = 8'h1C;
   localparam logic [7:0] ADDR_WINDOW    = 8'h40;
   localparam logic [7:0] WINDOW_MASK    = 8'hC0;
   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int TRIPLE_SAMPLE_BIT = 7;
   localparam int SEG_TWO_MSB       = 6;
   localparam int SEG_TWO_LSB       = 4;
   localparam int SEG_ONE_MSB       = 3;
   localparam int SEG_ONE_LSB       = 0;
   localparam int RX_ERR_MSB        = 5;
   localparam int RX_ERR_LSB        = 4;
   localparam int TX_ERR_MSB        = 3;
   localparam int TX_ERR_LSB        = 2;
   localparam logic [7:0] RX_FLAG_W1C_MASK = 8'hC3;
   // ***************************************************************
   // reset values and sizes
   // ***************************************************************
   localparam logic [7:0] RST_TIMING    = 8'h23;
   localparam logic [7:0] RST_PRESCALE  = 8'h01;
   localparam logic [2:0] RST_TX_EMPTY  = 3'h7;
   localparam logic [3:0] SEG_ONE_MIN   = 4'h3;
   localparam int NUM_TX_BUF            = 3;
   localparam int BUF_WORDS             = 16;
   localparam int LOCAL_PRIORITY_WORD             = 13;
   localparam int STAMP_HI_WORD         = 14;
   localparam int STAMP_LO_WORD         = 15;
   typedef enum {ST_IDLE, ST_SEND, ST_GAP} cbt_tx_state_t;
endpackage
`default_nettype wire

// [hw/cbt_buf_mem.sv]
// byte memory holding the three transmit buffers, registered read
`default_nettype none
module cbt_buf_mem (
   // clock
   input  wire logic       pclk,
   input  wire logic       ce,
   // write port
   input  wire logic       wr_en,
   input  wire logic [5:0] wr_addr,
   input  wire logic [7:0] wr_data,
   // read port
   input  wire logic [5:0] rd_addr,
   output var  logic [7:0] rd_data
);
   logic [7:0] mem [0:63];
   always_ff @(posedge pclk) begin
      if (ce) begin
         if (wr_en) begin
            mem[wr_addr] <= wr_data;
         end
         rd_data <= mem[rd_addr];
      end
   end
endmodule
`default_nettype wire

// [hw/cbt_sampler.sv]
// bus sampler: single sample or three-sample majority vote
`default_nettype none
module cbt_sampler (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ce,
   // controls
   input  wire logic triple_sample_sel,
   input  wire logic tq_tick,
   input  wire logic at_sample,
   input  wire logic near_sample,
   input  wire logic rx_pin,
   // result
   output var  logic bit_value
);
   logic [1:0] early;
   logic       vote;
   // majority of the two early quanta and the sample point
   assign vote = (early[0] & early[1]) | (early[0] & rx_pin) | (early[1] & rx_pin);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         early     <= 2'h3;
         bit_value <= 1'b1;
      end else if (ce && tq_tick) begin
         if (near_sample) begin
            early <= {early[0], rx_pin};
         end
         if (at_sample) begin
            bit_value <= triple_sample_sel ? vote : rx_pin;
         end
      end
   end
endmodule
`default_nettype wire

// [hw/cbt_top.sv]
// can bit timing, receiver flags and triple transmit buffer block
//
// Notes on behaviour
// - one sample, or three with majority vote
// - segment two field is value plus one
// - segment one field is value plus one
// - bit time prescale times quanta sum
// - timing writable only in init mode
// - flag clears on one once cause gone
// - each flag has an enable bit
// - flags held reset during init mode
// - error states read-only, kept in init
// - three independent transmit buffers
// - buffer: 13 bytes, priority, stamp
// - highest local priority goes first
// - rearbitrate at once, release on loss
// - empty flag marks a free buffer
// - selection maps buffer into window
`default_nettype none
module cbt_top
   import cbt_pkg::*;
(
   // clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // mode and receiver events
   input  wire logic        init_request,
   input  wire logic [3:0]  rx_flag_set,
   input  wire logic [1:0]  rx_error_state,
   input  wire logic [1:0]  tx_error_state,
   // can link
   input  wire logic        rx_pin,
   input  wire logic        arb_lost,
   input  wire logic        frame_done,
   output var  logic        tx_start,
   output var  logic [7:0]  tx_byte,
   output var  logic        tx_byte_valid,
   output var  logic        bit_value,
   output var  logic        init_acknowledge,
   output var  logic        rx_irq
);
   import cbt_pkg::*;

   // ***************************************************************
   // state record
   // ***************************************************************
   typedef struct packed {
      logic          init_ack;
      logic [7:0]    timing;
      logic [7:0]    prescale;
      logic [7:0]    rx_flags;
      logic [7:0]    rx_irq_en;
      logic [2:0]    tx_empty;
      logic [2:0]    tx_sel;
      logic          ready;
      logic          rd_pend;
      logic [31:0]   rdata;
      logic          slverr;
      cbt_tx_state_t st;
      logic [1:0]    cur_buf;
      logic [3:0]    byte_idx;
      logic          byte_valid;
      logic          start;
      logic [7:0]    pre_cnt;
      logic [4:0]    tq_cnt;
      logic          irq;
   } cbt_state_t;

   cbt_state_t q;
   cbt_state_t next_q;

   // ***************************************************************
   // helpers
   // ***************************************************************
   // lowest set bit among selected free buffers, 3 means none
   function automatic logic [1:0] lowest_set(input logic [2:0] v);
      logic [1:0] r;
      r = 2'h3;
      for (int i = NUM_TX_BUF - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 2'(i);
         end
      end
      return r;
   endfunction

   logic       in_init;
   logic       access;
   logic       wr_acc;
   logic       rd_acc;
   logic       win_hit;
   logic [1:0] fg_buf;
   logic [4:0] seg_one;
   logic [4:0] seg_two;
   logic [4:0] bit_len;
   logic       tq_tick;
   logic       at_sample;
   logic       near_sample;
   logic [7:0] mem_rd;
   logic       mem_we;
   logic [5:0] mem_waddr;
   logic [5:0] mem_raddr;
   logic [7:0] local_priority [0:2];
   logic [2:0] ready_buf;
   logic [1:0] best;

   assign in_init = init_request & q.init_ack;
   assign access  = psel & penable & q.ready;
   assign wr_acc  = access & pwrite;
   assign rd_acc  = access & ~pwrite;
   assign win_hit = (paddr & WINDOW_MASK) == ADDR_WINDOW;
   assign fg_buf  = lowest_set(q.tx_sel & q.tx_empty);

   // ***************************************************************
   // bit timing
   // ***************************************************************
   assign seg_one = {1'b0, q.timing[SEG_ONE_MSB:SEG_ONE_LSB]} + 5'h01;
   assign seg_two = {2'b00, q.timing[SEG_TWO_MSB:SEG_TWO_LSB]} + 5'h01;
   assign bit_len = seg_one + seg_two;
   assign tq_tick = (q.pre_cnt == 8'h00);
   assign at_sample   = (q.tq_cnt == seg_one);
   assign near_sample = (q.tq_cnt == seg_one - 5'h02) || (q.tq_cnt == seg_one - 5'h01);

   cbt_sampler u_sampler (
      .pclk              (pclk),
      .presetn           (presetn),
      .ce                (ce),
      .triple_sample_sel (q.timing[TRIPLE_SAMPLE_BIT]),
      .tq_tick           (tq_tick),
      .at_sample         (at_sample),
      .near_sample       (near_sample),
      .rx_pin            (rx_pin),
      .bit_value         (bit_value)
   );

   // ***************************************************************
   // buffer memory: buffer n at bytes 16n..16n+15
   // ***************************************************************
   assign mem_we    = wr_acc && win_hit && (fg_buf != 2'h3);
   assign mem_waddr = {fg_buf, paddr[5:2]};
   assign mem_raddr = (q.st == ST_SEND) ? {q.cur_buf, q.byte_idx} : {fg_buf, paddr[5:2]};

   cbt_buf_mem u_mem (
      .pclk    (pclk),
      .ce      (ce),
      .wr_en   (mem_we),
      .wr_addr (mem_waddr),
      .wr_data (pwdata[7:0]),
      .rd_addr (mem_raddr),
      .rd_data (mem_rd)
   );

   // priority copies kept in flops for the arbiter
   genvar g;
   generate
      for (g = 0; g < NUM_TX_BUF; g++) begin : g_local_priority
         logic [7:0] p;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               p <= 8'h00;
            end else if (ce && mem_we && fg_buf == 2'(g) && paddr[5:2] == 4'(LOCAL_PRIORITY_WORD)) begin
               p <= pwdata[7:0];
            end
         end
         assign local_priority[g]      = p;
         assign ready_buf[g] = ~q.tx_empty[g];
      end
   endgenerate

   // lower value is higher priority, ties to lowest index
   always_comb begin
      best = 2'h3;
      for (int i = NUM_TX_BUF - 1; i >= 0; i--) begin
         if (ready_buf[i] && (best == 2'h3 || local_priority[i] <= local_priority[best])) begin
            best = 2'(i);
         end
      end
   end

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      next_q = q;
      next_q.start      = 1'b0;
      next_q.byte_valid = 1'b0;
      next_q.init_ack   = init_request;
      // prescaler and quanta counter
      if (tq_tick) begin
         next_q.pre_cnt = q.prescale - 8'h01;
         next_q.tq_cnt  = (q.tq_cnt >= bit_len) ? 5'h00 : q.tq_cnt + 5'h01;
      end else begin
         next_q.pre_cnt = q.pre_cnt - 8'h01;
      end
      // apb: no wait state, window reads one
      next_q.ready  = 1'b0;
      next_q.slverr = 1'b0;
      if (psel && !penable) begin
         next_q.rd_pend = ~pwrite & win_hit;
         next_q.ready   = ~(~pwrite & win_hit);
      end else if (q.rd_pend) begin
         next_q.rd_pend = 1'b0;
         next_q.ready   = 1'b1;
      end
      // window read: memory word latched at setup stands now
      if (psel && penable && q.rd_pend && win_hit && !pwrite) begin
         next_q.rdata = {24'h0, mem_rd};
      end
      if (psel && !penable && !win_hit && !pwrite) begin
         case (paddr)
            ADDR_CONTROL:   next_q.rdata = {30'h0, q.init_ack, init_request};
            ADDR_RX_FLAGS:  next_q.rdata = {24'h0, q.rx_flags[7:6], rx_error_state,
                                            tx_error_state, q.rx_flags[1:0]};
            ADDR_RX_IRQ_EN: next_q.rdata = {24'h0, q.rx_irq_en};
            ADDR_TIMING:    next_q.rdata = {24'h0, q.timing};
            ADDR_TX_EMPTY:  next_q.rdata = {29'h0, q.tx_empty};
            ADDR_TX_SELECT: next_q.rdata = {29'h0, q.tx_sel};
            ADDR_PRESCALE:  next_q.rdata = {24'h0, q.prescale};
            ADDR_STATUS:    next_q.rdata = {27'h0, q.st == ST_SEND, fg_buf, best};
            default: begin
               next_q.rdata  = 32'h0;
               next_q.slverr = 1'b1;
            end
         endcase
      end
      if (psel && !penable && pwrite && !win_hit) begin
         case (paddr)
            ADDR_CONTROL, ADDR_RX_FLAGS, ADDR_RX_IRQ_EN, ADDR_TIMING, ADDR_TX_EMPTY,
            ADDR_TX_SELECT, ADDR_PRESCALE, ADDR_STATUS: next_q.slverr = 1'b0;
            default: next_q.slverr = 1'b1;
         endcase
      end
      // register writes
      if (wr_acc && !win_hit) begin
         case (paddr)
            ADDR_TIMING: begin
               if (in_init) begin
                  next_q.timing = pwdata[7:0];
               end
            end
            ADDR_PRESCALE: begin
               if (in_init && pwdata[7:0] != 8'h00) begin
                  next_q.prescale = pwdata[7:0];
               end
            end
            ADDR_RX_IRQ_EN: next_q.rx_irq_en = pwdata[7:0];
            ADDR_RX_FLAGS: begin
               if (!init_request && !q.init_ack) begin
                  next_q.rx_flags = q.rx_flags & ~(pwdata[7:0] & RX_FLAG_W1C_MASK);
               end
            end
            ADDR_TX_SELECT: next_q.tx_sel = pwdata[2:0];
            ADDR_TX_EMPTY: begin
               next_q.tx_empty = q.tx_empty & ~pwdata[2:0];
            end
            default: begin
               next_q.tx_sel = q.tx_sel;
            end
         endcase
      end
      // set wins over clear; cause still present keeps flag
      next_q.rx_flags[7:6] = next_q.rx_flags[7:6] | rx_flag_set[3:2];
      next_q.rx_flags[1:0] = next_q.rx_flags[1:0] | rx_flag_set[1:0];
      next_q.rx_flags[5:2] = 4'h0;
      if (in_init) begin
         next_q.rx_flags = 8'h00;
      end
      // transmit sequencer
      case (q.st)
         ST_IDLE: begin
            if (best != 2'h3 && !in_init) begin
               next_q.cur_buf  = best;
               next_q.byte_idx = 4'h0;
               next_q.start    = 1'b1;
               next_q.st       = ST_SEND;
            end
         end
         ST_SEND: begin
            if (arb_lost) begin
               next_q.st = ST_IDLE;
            end else begin
               next_q.byte_valid = (q.byte_idx != 4'h0) || q.start;
               if (q.byte_idx < 4'(LOCAL_PRIORITY_WORD - 1)) begin
                  next_q.byte_idx = q.byte_idx + 4'h1;
               end else begin
                  next_q.st = ST_GAP;
               end
            end
         end
         ST_GAP: begin
            if (arb_lost) begin
               next_q.st = ST_IDLE;
            end else if (frame_done) begin
               next_q.tx_empty[q.cur_buf] = 1'b1;
               next_q.st = ST_IDLE;
            end
         end
         default: next_q.st = ST_IDLE;
      endcase
      next_q.irq = |(next_q.rx_flags & q.rx_irq_en);
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q          <= '0;
         q.timing   <= RST_TIMING;
         q.prescale <= RST_PRESCALE;
         q.tx_empty <= RST_TX_EMPTY;
         q.st       <= ST_IDLE;
      end else if (ce) begin
         q <= next_q;
      end
   end

   assign prdata           = q.rdata;
   assign pready           = q.ready;
   assign pslverr          = q.slverr;
   assign tx_start         = q.start;
   assign tx_byte          = mem_rd;
   assign tx_byte_valid    = q.byte_valid;
   assign init_acknowledge = q.init_ack;
   assign rx_irq           = q.irq;
endmodule
`default_nettype wire

// [tb/cbt_chk.sv]
// assertion checker for the can timing and transmit buffer block
`default_nettype none
module cbt_chk (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // mode and link
   input wire logic init_request,
   input wire logic init_acknowledge,
   input wire logic tx_start,
   input wire logic tx_byte_valid,
   input wire logic rx_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // *****
   // properties
   // *****
   a_ack_follows_req: assert property ($past(presetn) && $past(ce) |-> init_acknowledge == $past(init_request))
      else $error("ack does not follow request");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_in_time: assert property (psel && !penable |-> ##[1:2] pready)
      else $error("pready late");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_start_one_cycle: assert property (tx_start |=> !tx_start)
      else $error("tx_start longer than one cycle");
   a_quiet_in_init: assert property ($past(init_request && init_acknowledge) && init_request
      && init_acknowledge |-> !tx_start)
      else $error("frame started in init mode");
   a_bytes_follow_start: assert property (tx_start |-> ##[1:4] tx_byte_valid)
      else $error("no byte after start");
   a_irq_quiet_init: assert property ((init_request && init_acknowledge)[*3] |-> !rx_irq)
      else $error("irq raised in init mode");
endmodule
bind cbt_top cbt_chk cbt_chk_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .init_request(init_request), .init_acknowledge(init_acknowledge),
   .tx_start(tx_start), .tx_byte_valid(tx_byte_valid), .rx_irq(rx_irq));
`default_nettype wire

// [tb/cbt_node.sv]
// model of the remote can nodes seen by the transmitter
`default_nettype none
module cbt_node (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // from the transmitter
   input  wire logic       tx_start,
   input  wire logic [7:0] tx_byte,
   input  wire logic       tx_byte_valid,
   // test controls
   input  wire logic       lose_once,
   input  wire logic [3:0] gap,
   // to the transmitter
   output var  logic       arb_lost,
   output var  logic       frame_done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] first_byte [8];
   int         frames;
   int         cnt;
   int         wait_n;
   logic       lost;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arb_lost <= 1'b0;
         frame_done <= 1'b0;
         frames = 0;
         cnt = -1;
         wait_n = 0;
         lost = 1'b0;
      end else begin
         arb_lost <= 1'b0;
         frame_done <= 1'b0;
         if (tx_start) begin
            cnt = 0;
         end else if (tx_byte_valid && cnt >= 0) begin
            if (cnt == 0 && frames < 8) begin
               first_byte[frames] = tx_byte;
            end
            cnt++;
            // another node wins the first arbitration
            if (lose_once && !lost) begin
               lost = 1'b1;
               arb_lost <= 1'b1;
               cnt = -1;
               frames++;
            end else if (cnt == 13) begin
               wait_n = gap + 1;
               cnt = -1;
               frames++;
            end
         end
         if (wait_n > 0) begin
            wait_n--;
            if (wait_n == 0) begin
               frame_done <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// [tb/tb_cbt_top.sv]
// self-checking bench for the can timing and transmit buffer block
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
   $display("FAIL %0t got %h exp %h", $time, g, e); end end
module tb_cbt_top;
   import cbt_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk, presetn, ce, psel, penable, pwrite, init_request, rx_pin;
   logic        pready, pslverr, arb_lost, frame_done, tx_start, tx_byte_valid;
   logic        bit_value, init_acknowledge, rx_irq, err, ok;
   logic [7:0]  paddr, tx_byte, t;
   logic [31:0] pwdata, prdata, rv;
   logic [3:0]  rx_flag_set;
   logic [1:0]  rx_error_state, tx_error_state;
   int          err_total, checks_done, n;
   logic [7:0]  pr [3] = '{8'h30, 8'h10, 8'h20};
   logic [7:0]  sel [3] = '{8'h07, 8'h06, 8'h04};
   logic [7:0]  order [4] = '{8'h11, 8'h11, 8'h12, 8'h10};
   cbt_top cbt_top_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .init_request(init_request), .rx_flag_set(rx_flag_set), .rx_error_state(rx_error_state),
      .tx_error_state(tx_error_state), .rx_pin(rx_pin), .arb_lost(arb_lost), .frame_done(frame_done),
      .tx_start(tx_start), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid), .bit_value(bit_value),
      .init_acknowledge(init_acknowledge), .rx_irq(rx_irq));
   cbt_node cbt_node_i (.pclk(pclk), .presetn(presetn), .tx_start(tx_start), .tx_byte(tx_byte),
      .tx_byte_valid(tx_byte_valid), .lose_once(1'b1), .gap(4'h3), .arb_lost(arb_lost),
      .frame_done(frame_done));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // *****
   // tasks
   // *****
   task automatic results();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      ok = pready;
      rv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (ok !== 1'b1) begin
         err_total++;
         results();
      end
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rv, e)
   endtask
   task automatic set_init(input logic v);
      init_request <= v;
      repeat (3) @(posedge pclk);
   endtask
   initial begin
      repeat (50000) @(posedge pclk);
      err_total++;
      results();
   end
   // *****
   // sequence
   // *****
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, init_request} = '0;
      ce = 1'b1;
      {rx_flag_set, rx_error_state, tx_error_state} = '0;
      rx_pin = 1'b1;
      err_total = 0;
      checks_done = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK(bit_value, 1'b1)
      chk_rd(ADDR_TIMING, 32'h23);
      chk_rd(ADDR_PRESCALE, 32'h1);
      chk_rd(ADDR_TX_EMPTY, 32'h7);
      chk_rd(ADDR_RX_FLAGS, 32'h0);
      apb(1'b0, 8'h30, 32'h0);
      `CHK({err, rv}, 33'h100000000)
      apb(1'b1, ADDR_TIMING, 32'hA5);
      chk_rd(ADDR_TIMING, 32'h23);
      set_init(1'b1);
      chk_rd(ADDR_CONTROL, 32'h3);
      rx_flag_set <= 4'hF;
      rx_error_state <= 2'h2;
      tx_error_state <= 2'h1;
      repeat (2) @(posedge pclk);
      chk_rd(ADDR_RX_FLAGS, 32'h24);
      apb(1'b1, ADDR_PRESCALE, 32'h2);
      chk_rd(ADDR_PRESCALE, 32'h2);
      // single then triple sampling; phase one kept at four quanta
      for (int m = 0; m < 2; m++) begin
         t = m ? 8'hB3 : 8'h23;
         apb(1'b1, ADDR_TIMING, {24'h0, t});
         chk_rd(ADDR_TIMING, {24'h0, t});
         for (int v = 0; v < 2; v++) begin
            rx_pin <= v[0];
            repeat (8 * (3 + t[3:0] + t[6:4])) @(posedge pclk);
            `CHK(bit_value, v[0])
         end
      end
      // enable low freezes the sampler while the pin moves
      ce <= 1'b0;
      rx_pin <= 1'b0;
      repeat (100) @(posedge pclk);
      `CHK(bit_value, 1'b1)
      ce <= 1'b1;
      rx_pin <= 1'b1;
      apb(1'b1, ADDR_TIMING, 32'h23);
      chk_rd(ADDR_TIMING, 32'h23);
      set_init(1'b0);
      chk_rd(ADDR_RX_FLAGS, 32'hE7);
      apb(1'b1, ADDR_RX_FLAGS, 32'hFF);
      chk_rd(ADDR_RX_FLAGS, 32'hE7);
      rx_flag_set <= 4'h0;
      apb(1'b1, ADDR_RX_FLAGS, 32'h01);
      chk_rd(ADDR_RX_FLAGS, 32'hE6);
      for (int e = 0; e < 2; e++) begin
         apb(1'b1, ADDR_RX_IRQ_EN, e ? 32'h01 : 32'h02);
         repeat (2) @(posedge pclk);
         `CHK(rx_irq, ~e[0])
      end
      set_init(1'b1);
      set_init(1'b0);
      chk_rd(ADDR_RX_FLAGS, 32'h24);
      for (int b = 0; b < 3; b++) begin
         apb(1'b1, ADDR_TX_SELECT, {24'h0, sel[b]});
         apb(1'b1, ADDR_WINDOW, 32'h10 + b);
         apb(1'b1, ADDR_WINDOW + 8'(LOCAL_PRIORITY_WORD * 4), {24'h0, pr[b]});
      end
      for (int b = 0; b < 3; b++) begin
         apb(1'b1, ADDR_TX_SELECT, {24'h0, sel[b]});
         chk_rd(ADDR_WINDOW, 32'h10 + b);
      end
      apb(1'b1, ADDR_TX_EMPTY, 32'h7);
      n = 0;
      do begin
         apb(1'b0, ADDR_TX_EMPTY, 32'h0);
         n++;
      end while (rv !== 32'h7 && n < 300);
      `CHK(rv, 32'h7)
      `CHK(cbt_node_i.frames, 4)
      for (int i = 0; i < 4; i++) begin
         `CHK(cbt_node_i.first_byte[i], order[i])
      end
      results();
   end
endmodule
`default_nettype wire
